// ---- core/echo_suppression_control.sv ----
// Purpose: Echo suppression state control with speech comparators
// Assumes: Inputs synchronous to clk; one sample stream word per 125 us
// Notes: Summary of operation below; loss values in quarter dB
`timescale 1ns/100ps
`include "echo_supp_defines.svh"

module echo_suppression_control (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Sample stream in
  input wire logic in_valid,
  input wire echo_supp_pkg::levels_t in_levels,
  output logic in_ready,
  // Attenuation stream out
  output logic out_valid,
  output echo_supp_pkg::att_out_t out_data,
  input wire logic out_ready,
  // Speech detector decisions and gain sources
  input wire logic tx_speech_raw,
  input wire logic rx_speech_raw,
  input wire logic [6:0] echo_cancel_loss,
  input wire logic signed [7:0] transmit_auto_gain,
  input wire logic signed [7:0] receive_auto_gain,
  // Parameters; index 0 acoustic, index 1 line
  input wire echo_supp_pkg::comp_params_t [1:0] comp_params,
  input wire echo_supp_pkg::att_params_t att_params,
  // Status
  output logic transmit_speech_detector,
  output logic receive_speech_detector,
  output logic [1:0] comparator_request,
  output logic [1:0] state_status_pins,
  output logic [1:0] state_status_register
);

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  // Log compression: about 6 dB per octave plus two mantissa bits
  function automatic logic [7:0] log_hdb(input logic [15:0] x);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 2; i < 16; i++) begin
      if (x[i]) begin
        r = 8'(12 * i + 3 * int'(x[i-1 -: 2]));
      end
    end
    return r;
  endfunction : log_hdb
  function automatic logic [1:0] pins_of(input echo_supp_pkg::state_t s);
    case (s)
      echo_supp_pkg::ST_IDLE: pins_of = `PINS_IDLE;
      echo_supp_pkg::ST_TX: pins_of = `PINS_TRANSMIT;
      echo_supp_pkg::ST_RX: pins_of = `PINS_RECEIVE;
      default: pins_of = `PINS_INACTIVE;
    endcase
  endfunction : pins_of

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry input buffer
  echo_supp_pkg::levels_t buf_mem [0:1];
  logic wr_ptr_reg;
  logic rd_ptr_reg;
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic push;
  logic take;
  echo_supp_pkg::levels_t head;
  assign push = in_valid && in_ready;
  // A stalled receiver holds the output word, so the buffer fills
  assign take = (cnt_reg != 2'h0) && (!out_valid || out_ready);
  assign head = buf_mem[rd_ptr_reg];
  assign cnt_next = 2'(cnt_reg + {1'b0, push} - {1'b0, take});
  always_ff @(posedge clk) begin
    if (push) buf_mem[wr_ptr_reg] <= in_levels;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      cnt_reg <= 2'h0;
      in_ready <= 1'b0;
    end else begin
      if (push) wr_ptr_reg <= ~wr_ptr_reg;
      if (take) rd_ptr_reg <= ~rd_ptr_reg;
      cnt_reg <= cnt_next;
      in_ready <= (cnt_next != 2'h2);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Parameter shadows and sample timing
  echo_supp_pkg::comp_params_t [1:0] cp_reg;
  echo_supp_pkg::att_params_t ap_reg;
  logic [3:0] samp_cnt_reg;
  logic ms_tick;
  assign ms_tick = take && (samp_cnt_reg == `SAMPLES_PER_MS - 4'h1);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cp_reg <= '0;
      ap_reg <= '0;
      samp_cnt_reg <= 4'h0;
      transmit_speech_detector <= 1'b0;
      receive_speech_detector <= 1'b0;
    end else if (take) begin
      cp_reg <= comp_params;
      ap_reg <= att_params;
      samp_cnt_reg <= ms_tick ? 4'h0 : 4'(samp_cnt_reg + 4'h1);
      transmit_speech_detector <= tx_speech_raw;
      receive_speech_detector <= rx_speech_raw;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Speech comparators
  logic [1:0] req;
  logic [1:0] comp_speech;
  logic [15:0] send_lin [0:1];
  logic [15:0] ret_lin [0:1];
  assign comp_speech = {receive_speech_detector, transmit_speech_detector};
  assign send_lin[0] = head.mic;
  assign ret_lin[0] = head.spk;
  assign send_lin[1] = head.line_in;
  assign ret_lin[1] = head.line_out;
  for (genvar gi = 0; gi < 2; gi++) begin : g_comp
    logic [11:0] reserve_reg;
    logic [9:0] hold_reg;
    logic speech_prm_reg;
    logic req_reg;
    logic signed [15:0] send_fine;
    logic signed [15:0] thresh_fine;
    logic [11:0] dec;
    logic [9:0] hold_lim;
    // Both sides compared as log levels
    assign send_fine = 16'(signed'({8'h00, log_hdb(send_lin[gi])}) * `HDB_TO_FINE);
    // Threshold is return level plus base gain plus reserve
    assign thresh_fine = 16'(signed'({8'h00, log_hdb(ret_lin[gi])}) * `HDB_TO_FINE
      + cp_reg[gi].base_gain * `DB_TO_FINE + signed'({4'h0, reserve_reg}));
    // Decay rate follows the active parameter set
    assign dec = speech_prm_reg ? 12'(cp_reg[gi].speech_peak_decrement)
                                : 12'(cp_reg[gi].noise_peak_decrement);
    assign hold_lim = 10'(cp_reg[gi].speech_hold_time * `HOLD_UNIT_MS);
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        reserve_reg <= 12'h000;
        hold_reg <= 10'h000;
        speech_prm_reg <= 1'b0;
        req_reg <= 1'b0;
      end else if (take) begin
        req_reg <= send_fine > thresh_fine;
        if (comp_speech[gi]) begin
          reserve_reg <= 12'(cp_reg[gi].speech_gain_reserve * `DB_TO_FINE);
          hold_reg <= 10'h000;
          speech_prm_reg <= 1'b1;
        end else if (ms_tick) begin
          if (speech_prm_reg && hold_reg < hold_lim) begin
            hold_reg <= 10'(hold_reg + 10'h001);
          end else begin
            speech_prm_reg <= 1'b0;
            // Reserve decays to zero, so the floor is the base gain
            reserve_reg <= (reserve_reg > dec) ? 12'(reserve_reg - dec) : 12'h000;
          end
        end
      end
    end
    assign req[gi] = req_reg;
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      comparator_request <= 2'h0;
    end else begin
      comparator_request <= req;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State control
  echo_supp_pkg::state_t state_reg;
  logic [11:0] quiet_reg;
  logic slow_ramp_reg;
  logic go_tx;
  logic go_rx;
  logic timed_out;
  logic any_speech;
  // Each switch pairs one comparator with its own detector
  assign go_tx = req[0] && transmit_speech_detector;
  assign go_rx = req[1] && receive_speech_detector;
  assign any_speech = transmit_speech_detector || receive_speech_detector;
  assign timed_out = !any_speech
    && quiet_reg >= 12'(ap_reg.idle_timeout * `TIMEOUT_UNIT_MS)
    && ap_reg.idle_ramp_speed != `IDLE_DISABLE;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      quiet_reg <= 12'h000;
    end else if (take) begin
      if (any_speech || state_reg == echo_supp_pkg::ST_IDLE) begin
        quiet_reg <= 12'h000;
      end else if (ms_tick && quiet_reg != 12'hfff) begin
        quiet_reg <= 12'(quiet_reg + 12'h001);
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= echo_supp_pkg::ST_OFF;
      slow_ramp_reg <= 1'b0;
    end else if (take) begin
      if (!ap_reg.enable) begin
        state_reg <= echo_supp_pkg::ST_OFF;
        slow_ramp_reg <= 1'b0;
      end else begin
        case (state_reg)
          echo_supp_pkg::ST_OFF: state_reg <= echo_supp_pkg::ST_IDLE;
          echo_supp_pkg::ST_IDLE: begin
            // Acoustic side wins a tie: near-end talker is louder in the room
            if (go_tx) begin
              state_reg <= echo_supp_pkg::ST_TX;
              slow_ramp_reg <= 1'b0;
            end else if (go_rx) begin
              state_reg <= echo_supp_pkg::ST_RX;
              slow_ramp_reg <= 1'b0;
            end
          end
          echo_supp_pkg::ST_TX: begin
            if (go_rx) begin
              state_reg <= echo_supp_pkg::ST_RX;
              slow_ramp_reg <= 1'b0;
            end else if (timed_out) begin
              state_reg <= echo_supp_pkg::ST_IDLE;
              slow_ramp_reg <= 1'b1;
            end
          end
          echo_supp_pkg::ST_RX: begin
            if (go_tx) begin
              state_reg <= echo_supp_pkg::ST_TX;
              slow_ramp_reg <= 1'b0;
            end else if (timed_out) begin
              state_reg <= echo_supp_pkg::ST_IDLE;
              slow_ramp_reg <= 1'b1;
            end
          end
          default: state_reg <= echo_supp_pkg::ST_OFF;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Loss distribution and ramping
  logic signed [10:0] loss_raw;
  logic [8:0] loss_q;
  logic [8:0] tx_tgt;
  logic [8:0] rx_tgt;
  logic [8:0] tx_att_reg;
  logic [8:0] rx_att_reg;
  logic [23:0] step_cnt_reg;
  logic [23:0] period;
  logic step;
  // Canceller loss removed, positive auto gain added back
  assign loss_raw = 11'(signed'({4'h0, ap_reg.total_loss_setting})
    - signed'({4'h0, echo_cancel_loss})
    + (transmit_auto_gain > 0 ? 11'(transmit_auto_gain) : 11'sh000)
    + (receive_auto_gain > 0 ? 11'(receive_auto_gain) : 11'sh000));
  assign loss_q = loss_raw < 0 ? 9'h000
    : loss_raw > `MAX_LOSS_DB ? 9'(`MAX_LOSS_DB * `STEPS_PER_DB)
    : 9'(loss_raw * `STEPS_PER_DB);
  always_comb begin
    case (state_reg)
      echo_supp_pkg::ST_TX: begin
        tx_tgt = 9'h000;
        rx_tgt = loss_q;
      end
      echo_supp_pkg::ST_RX: begin
        tx_tgt = loss_q;
        rx_tgt = 9'h000;
      end
      echo_supp_pkg::ST_IDLE: begin
        tx_tgt = {1'b0, loss_q[8:1]};
        rx_tgt = {1'b0, loss_q[8:1]};
      end
      default: begin
        tx_tgt = 9'h000;
        rx_tgt = 9'h000;
      end
    endcase
  end
  // Fixed time per quarter dB gives total time = rate x loss
  assign period = slow_ramp_reg ? 24'(ap_reg.idle_ramp_speed * `DS_STEP_CYC)
                                : 24'(ap_reg.state_change_rate * `SW_STEP_CYC);
  assign step = (step_cnt_reg + 24'h1 >= period);
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      step_cnt_reg <= 24'h0;
    end else begin
      step_cnt_reg <= step ? 24'h0 : 24'(step_cnt_reg + 24'h1);
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      tx_att_reg <= 9'h000;
      rx_att_reg <= 9'h000;
    end else if (state_reg == echo_supp_pkg::ST_OFF) begin
      tx_att_reg <= 9'h000;
      rx_att_reg <= 9'h000;
    end else if (step) begin
      if (tx_att_reg < tx_tgt) tx_att_reg <= 9'(tx_att_reg + 9'h001);
      else if (tx_att_reg > tx_tgt) tx_att_reg <= 9'(tx_att_reg - 9'h001);
      if (rx_att_reg < rx_tgt) rx_att_reg <= 9'(rx_att_reg + 9'h001);
      else if (rx_att_reg > rx_tgt) rx_att_reg <= 9'(rx_att_reg - 9'h001);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output word and status
  logic lh_active;
  // Speaker amplifier takes over receive loss when needed
  assign lh_active = ap_reg.loudhearing_select && rx_att_reg != 9'h000;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_data <= '0;
    end else if (take) begin
      out_valid <= 1'b1;
      out_data.transmit_attenuator <= tx_att_reg;
      out_data.receive_attenuator <= lh_active ? 9'h000 : rx_att_reg;
      out_data.amp_override_en <= lh_active;
      out_data.amp_override_value <= ap_reg.speaker_amp_override_value;
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_status_pins <= `PINS_INACTIVE;
      state_status_register <= `PINS_INACTIVE;
    end else begin
      state_status_pins <= pins_of(state_reg);
      state_status_register <= pins_of(state_reg);
    end
  end
endmodule : echo_suppression_control

// ---- core/echo_supp_defines.svh ----
// Purpose: Constants for the echo suppression control block
// Assumes: 50 MHz clock, 8 kHz sample stream
// Notes: Attenuator values are in quarter-dB steps
`ifndef ECHO_SUPP_DEFINES_SVH
`define ECHO_SUPP_DEFINES_SVH

`define CLK_PERIOD_NS 20
`define SAMPLES_PER_MS 4'h8
`define STEPS_PER_DB 4
// Hold time field counts 4 ms, idle timeout field counts 16 ms
`define HOLD_UNIT_MS 4
`define TIMEOUT_UNIT_MS 16
// One unit of the change-rate field, and of the idle ramp field
`define SW_UNIT_NS 5200
`define DS_UNIT_NS 2680000
`define SW_STEP_CYC (`SW_UNIT_NS / `CLK_PERIOD_NS / `STEPS_PER_DB)
`define DS_STEP_CYC (`DS_UNIT_NS / `CLK_PERIOD_NS / `STEPS_PER_DB)
// Comparator arithmetic runs in 0.025 dB units
`define DB_TO_FINE 40
`define HDB_TO_FINE 20
`define MAX_LOSS_DB 95
`define IDLE_DISABLE 8'hff
// Status pin codes, bit 0 is the first pin
`define PINS_INACTIVE 2'h0
`define PINS_RECEIVE 2'h2
`define PINS_TRANSMIT 2'h1
`define PINS_IDLE 2'h3

`endif

// ---- core/echo_supp_pkg.sv ----
// Purpose: Types for the echo suppression control block
// Assumes: Constants live in echo_supp_defines.svh
// Notes: One-hot state codes
package echo_supp_pkg;

  typedef enum logic [3:0] {
    ST_OFF = 4'h1,
    ST_IDLE = 4'h2,
    ST_TX = 4'h4,
    ST_RX = 4'h8
  } state_t;

  // Linear magnitudes of the four signals at one sample
  typedef struct packed {
    logic [15:0] mic;
    logic [15:0] spk;
    logic [15:0] line_in;
    logic [15:0] line_out;
  } levels_t;

  typedef struct packed {
    logic signed [7:0] base_gain;
    logic [7:0] speech_gain_reserve;
    logic [7:0] speech_peak_decrement;
    logic [7:0] noise_gain_reserve;
    logic [7:0] noise_peak_decrement;
    logic [7:0] speech_hold_time;
  } comp_params_t;

  typedef struct packed {
    logic enable;
    logic loudhearing_select;
    logic [3:0] speaker_amp_override_value;
    logic [6:0] total_loss_setting;
    logic [7:0] idle_timeout;
    logic [7:0] idle_ramp_speed;
    logic [10:0] state_change_rate;
  } att_params_t;

  typedef struct packed {
    logic [8:0] transmit_attenuator;
    logic [8:0] receive_attenuator;
    logic amp_override_en;
    logic [3:0] amp_override_value;
  } att_out_t;

endpackage : echo_supp_pkg

// ---- verif/echo_supp_assertions.sv ----
// Purpose: Port checks for echo suppression control
// Assumes: Bound to the top module, one clock domain
// Notes: Loss values in quarter dB
`timescale 1ns/100ps
`include "echo_supp_defines.svh"
module echo_supp_assertions (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Streams
  input wire logic in_valid,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire echo_supp_pkg::att_out_t out_data,
  input wire logic out_ready,
  // Control and status
  input wire echo_supp_pkg::att_params_t att_params,
  input wire logic [1:0] state_status_pins,
  input wire logic [1:0] state_status_register
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [2:0] occ_reg;
  logic [3:0] off_reg;
  logic push;
  logic pop;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // Words held in buffer plus output slot
  always_ff @(posedge clk) begin
    if (!rst_n) occ_reg <= 3'h0;
    else occ_reg <= occ_reg + {2'h0, push} - {2'h0, pop};
  end
  // Saturating count of cycles with the unit disabled
  always_ff @(posedge clk) begin
    if (!rst_n || att_params.enable) off_reg <= 4'h0;
    else if (off_reg != 4'hf) off_reg <= off_reg + 4'h1;
  end
  ////////////////////////////////////////////////////////////
  sequence fresh_word;
    out_valid && (!$past(out_valid) || $past(out_ready));
  endsequence
  a_off_pins: assert property (off_reg >= 4'h3 |-> state_status_pins == `PINS_INACTIVE)
    else $error("pins not low while disabled");
  a_off_loss: assert property (off_reg >= 4'h4 ##0 fresh_word |->
    out_data.transmit_attenuator == 9'h0 && out_data.receive_attenuator == 9'h0)
    else $error("loss applied while disabled");
  a_reg_mirror: assert property (state_status_register == state_status_pins)
    else $error("status register differs from pins");
  a_override_rx: assert property (out_valid && out_data.amp_override_en |->
    out_data.receive_attenuator == 9'h0)
    else $error("receive loss kept during amplifier override");
  a_loss_ceiling: assert property (out_valid |->
    out_data.transmit_attenuator <= `MAX_LOSS_DB * `STEPS_PER_DB &&
    out_data.receive_attenuator <= `MAX_LOSS_DB * `STEPS_PER_DB)
    else $error("loss above ceiling");
  a_off_to_idle: assert property ($past(state_status_pins) == `PINS_INACTIVE &&
    state_status_pins != `PINS_INACTIVE |-> state_status_pins == `PINS_IDLE)
    else $error("left inactive to a state other than idle");
  a_idle_guard: assert property (state_status_pins == `PINS_IDLE &&
    $past(state_status_pins) inside {`PINS_TRANSMIT, `PINS_RECEIVE} |->
    $past(att_params.idle_ramp_speed, 2) != `IDLE_DISABLE)
    else $error("idle entered while disabled by ramp field");
  a_hold_word: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("output word dropped or changed while stalled");
  a_ready_release: assert property ($rose(rst_n) |-> !in_ready && !out_valid ##1 in_ready)
    else $error("input ready wrong after reset");
  a_occupancy: assert property (occ_reg <= 3'h3)
    else $error("more words held than slots");
  c_tx: cover property (state_status_pins == `PINS_TRANSMIT);
  c_rx: cover property (state_status_pins == `PINS_RECEIVE);
  c_idle: cover property (state_status_pins == `PINS_IDLE);
  c_amp: cover property (out_valid && out_data.amp_override_en);
endmodule : echo_supp_assertions

// ---- verif/echo_supp_far_end.sv ----
// Purpose: Far end that takes attenuation words
// Assumes: Ready changes at the falling edge
// Notes: Random stalls; stall input holds it off fully
`timescale 1ns/100ps
module echo_supp_far_end (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Attenuation stream
  input wire logic out_valid,
  input wire echo_supp_pkg::att_out_t out_data,
  output logic out_ready,
  // Bench side
  input wire logic stall,
  output echo_supp_pkg::att_out_t last_word,
  output int words
);
  initial begin
    out_ready = 1'b0;
    last_word = '0;
    words = 0;
  end
  // Takes override words as a front end set up for them
  always @(posedge clk) begin
    if (rst_n && out_valid && out_ready) begin
      last_word <= out_data;
      words <= words + 1;
    end
  end
  // Ready three cycles in four, so the buffer sees stalls
  always @(negedge clk) begin
    out_ready <= !stall && ($urandom_range(3) != 0);
  end
endmodule : echo_supp_far_end

// ---- verif/echo_suppression_control_tb_top.sv ----
// Purpose: Self-checking bench for echo suppression control
// Assumes: Far end model takes the output stream
// Notes: Small rate fields keep loss ramps short
`timescale 1ns/100ps
`include "echo_supp_defines.svh"
module echo_suppression_control_tb_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic in_valid = 1'b0;
  logic tx_raw = 1'b0;
  logic rx_raw = 1'b0;
  logic stall = 1'b0;
  logic [6:0] ec_loss = 7'h0;
  logic signed [7:0] agc_x = 8'sh00;
  logic signed [7:0] agc_r = 8'sh00;
  logic in_ready, out_valid, out_ready, tx_det, rx_det;
  logic [1:0] creq, pins, pins_reg;
  logic [8:0] g;
  echo_supp_pkg::levels_t lv = '0;
  echo_supp_pkg::att_out_t out_data, last_word;
  echo_supp_pkg::comp_params_t [1:0] cp = '0;
  echo_supp_pkg::att_params_t ap = '0;
  int words, sent;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  echo_suppression_control echo_suppression_control_i (
    .clk(clk), .rst_n(rst_n), .in_valid(in_valid), .in_levels(lv), .in_ready(in_ready),
    .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
    .tx_speech_raw(tx_raw), .rx_speech_raw(rx_raw), .echo_cancel_loss(ec_loss),
    .transmit_auto_gain(agc_x), .receive_auto_gain(agc_r), .comp_params(cp),
    .att_params(ap), .transmit_speech_detector(tx_det), .receive_speech_detector(rx_det),
    .comparator_request(creq), .state_status_pins(pins), .state_status_register(pins_reg));
  echo_supp_far_end echo_supp_far_end_i (
    .clk(clk), .rst_n(rst_n), .out_valid(out_valid), .out_data(out_data),
    .out_ready(out_ready), .stall(stall), .last_word(last_word), .words(words));
  always #10 clk = ~clk;
  ////////////////////////////////////////////////////////////
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      $display("FAIL %0t watchdog expired", $time);
      finish_test();
    end
  end
  task automatic check_field(input logic [15:0] got, input logic [15:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask : check_field
  task automatic check_word(input echo_supp_pkg::att_out_t got,
                            input echo_supp_pkg::att_out_t exp);
    echo_supp_pkg::att_out_t m;
    m = got;
    // Override value means nothing while override is off
    if (!exp.amp_override_en) m.amp_override_value = exp.amp_override_value;
    total_checks++;
    if (m !== exp) begin
      bad_count++;
      $display("FAIL %0t word got %h want %h", $time, got, exp);
    end
  endtask : check_word
  function automatic echo_supp_pkg::att_out_t exp_word(input logic [1:0] code);
    echo_supp_pkg::att_out_t w;
    w = '0;
    case (code)
      `PINS_TRANSMIT: w.receive_attenuator = g;
      `PINS_RECEIVE: w.transmit_attenuator = g;
      `PINS_IDLE: begin
        w.receive_attenuator = g >> 1;
        w.transmit_attenuator = g >> 1;
      end
      default: ;
    endcase
    if (ap.loudhearing_select && w.receive_attenuator != 9'h0) begin
      w.receive_attenuator = 9'h0;
      w.amp_override_en = 1'b1;
      w.amp_override_value = ap.speaker_amp_override_value;
    end
    return w;
  endfunction : exp_word
  // Kind 0 random levels, 1 loud microphone, 2 loud line input
  task automatic run(input int n, input logic tx, input logic rx, input int kind);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      tx_raw = tx;
      rx_raw = rx;
      lv = {$urandom, $urandom};
      if (kind == 1) lv = {16'hffff, 48'h0};
      if (kind == 2) lv = {32'h0, 16'hffff, 16'h0};
      in_valid = 1'b1;
      while (!in_ready) @(negedge clk);
      @(posedge clk);
    end
    @(negedge clk);
    in_valid = 1'b0;
  endtask : run
  task automatic check_state(input logic [1:0] code, input logic tx);
    check_field(pins, code, "pins");
    check_field(pins_reg, code, "status reg");
    check_field(tx_det, tx, "detector");
    check_field(rx_det, rx_raw, "rx detector");
    check_word(last_word, exp_word(code));
    $display("test state %h done", code);
  endtask : check_state
  ////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(17));
    for (int k = 0; k < 2; k++) begin
      cp[k].base_gain = 8'($urandom_range(16)) - 8'h08;
      cp[k].speech_gain_reserve = 8'($urandom_range(6));
      cp[k].noise_gain_reserve = 8'($urandom_range(6));
      cp[k].speech_peak_decrement = 8'($urandom_range(240, 1));
      cp[k].noise_peak_decrement = 8'($urandom_range(240, 1));
      cp[k].speech_hold_time = 8'($urandom_range(248));
    end
    ap.total_loss_setting = 7'($urandom_range(20, 8));
    ec_loss = 7'($urandom_range(4));
    g = 9'(ap.total_loss_setting - ec_loss) * 9'h4;
    ap.state_change_rate = 11'h1;
    ap.idle_timeout = 8'h1;
    ap.idle_ramp_speed = 8'h0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    rst_n = 1'b1;
    check_field(pins, 2'h0, "pins after reset");
    // Fill with the far end stalled, then drain
    stall = 1'b1;
    sent = 0;
    repeat (2) @(negedge clk);
    in_valid = 1'b1;
    repeat (8) begin
      if (in_ready) sent++;
      @(negedge clk);
    end
    in_valid = 1'b0;
    check_field(sent, 3, "words accepted");
    stall = 1'b0;
    for (int t = 0; t < 50 && words < 3; t++) @(negedge clk);
    check_field(words, 3, "words drained");
    check_word(last_word, '0);
    check_field(pins, 2'h0, "pins disabled");
    $display("test buffer done");
    ap.enable = 1'b1;
    run(3000, 0, 0, 0);
    check_state(`PINS_IDLE, 1'b0);
    run(3000, 1, 0, 1);
    check_state(`PINS_TRANSMIT, 1'b1);
    check_field(creq[0], 1'b1, "acoustic request");
    run(6000, 0, 1, 2);
    check_state(`PINS_RECEIVE, 1'b0);
    check_field(creq[1], 1'b1, "line request");
    run(400, 0, 0, 0);
    check_state(`PINS_IDLE, 1'b0);
    ap.idle_ramp_speed = `IDLE_DISABLE;
    run(3000, 1, 0, 1);
    run(400, 0, 0, 0);
    check_state(`PINS_TRANSMIT, 1'b0);
    // Positive transmit gain adds loss, a negative receive gain adds none
    agc_x = 8'($urandom_range(6, 1));
    agc_r = 8'shfd;
    g = 9'(ap.total_loss_setting - ec_loss + agc_x) * 9'h4;
    run(2000, 0, 0, 0);
    check_state(`PINS_TRANSMIT, 1'b0);
    ap.loudhearing_select = 1'b1;
    ap.speaker_amp_override_value = 4'($urandom);
    run(20, 0, 0, 0);
    check_state(`PINS_TRANSMIT, 1'b0);
    finish_test();
  end
endmodule : echo_suppression_control_tb_top
bind echo_suppression_control echo_supp_assertions echo_supp_assertions_i (
  .clk(clk), .rst_n(rst_n), .in_valid(in_valid), .in_ready(in_ready),
  .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
  .att_params(att_params), .state_status_pins(state_status_pins),
  .state_status_register(state_status_register));
